/* src/ssp_pkg.sv */
// package for the synchronous slave serial port: register map, fields, types
package ssp_pkg;
	localparam logic [7:0] ADDR_TX_STAT = 8'h00;
	localparam logic [7:0] ADDR_RX_STAT = 8'h04;
	localparam logic [7:0] ADDR_RX_DATA = 8'h08;
	localparam logic [7:0] ADDR_TX_DATA = 8'h0C;
	localparam logic [7:0] ADDR_CORE_IRQ = 8'h10;
	localparam logic [7:0] ADDR_PIE = 8'h14;
	localparam logic [7:0] ADDR_PIR = 8'h18;
	localparam logic [7:0] ADDR_BAUD = 8'h1C;
	localparam logic [7:0] ADDR_ALT_PIN = 8'h20;
	localparam logic [7:0] ADDR_EVT_STAT = 8'h24;
	localparam logic [7:0] ADDR_EVT_MASK = 8'h28;
	localparam logic [7:0] ADDR_SLEEP = 8'h2C;
	// transmit_status_control bits
	localparam int TX_CLOCK_SOURCE_MASTER = 7;
	localparam int TX_NINE = 6;
	localparam int TX_EN = 5;
	localparam int TX_SYNC = 4;
	localparam int TX_TRMT = 1;
	localparam int TX_NINE_D = 0;
	// receive_status_control bits
	localparam int RX_SERIAL_PORT_ENABLE = 7;
	localparam int RX_NINE = 6;
	localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
	localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int RX_OVERRUN_ERROR = 1;
	localparam int RX_NINE_D = 0;
	// core_irq_control, peripheral enable/flag and baud receive-idle positions
	localparam int CI_GIE = 7;
	localparam int CI_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int PI_RC = 5;
	localparam int PI_TX = 4;
	localparam int BAUD_RCIDL = 6;
	// event status bits
	localparam int EV_RX = 0;
	localparam int EV_TX = 1;
	localparam int EV_OVR = 2;
	localparam logic [7:0] TXS_RESET = 8'h02;
	localparam logic [7:0] PIR_RESET = 8'h10;
	localparam logic [7:0] BAUD_RESET = 8'h40;
	localparam int FIFO_DEPTH = 2;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	typedef struct packed {
		logic clk;
		logic data;
	} ssp_pins_t;
endpackage : ssp_pkg

/* src/ssp_slave.sv */
// synchronous slave serial port with ahb-lite register access
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ssp_slave
	import ssp_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic SER_CLK_IN,
	input wire logic SER_DATA_IN,
	output logic SER_DATA_OUT,
	output logic SER_DATA_OE,
	input wire logic CORE_SLEEP,
	output logic CORE_WAKE,
	output logic CORE_VECTOR,
	output logic IRQ
);
	typedef struct packed {
		logic [1:0] ck_sync;
		logic [1:0] dt_sync;
		logic ck_prev;
		logic [7:0] txs;
		logic [7:0] rxs;
		logic [7:0] core_irq;
		logic [7:0] pie;
		logic [7:0] pir;
		logic [7:0] baud;
		logic [7:0] alt_pin;
		logic [2:0] evt;
		logic [2:0] evt_mask;
		logic [8:0] receive_shift_register;
		logic [3:0] rx_cnt;
		logic [8:0] fifo0;
		logic [8:0] fifo1;
		logic [1:0] fifo_cnt;
		logic [8:0] transmit_shift_register;
		logic [3:0] tx_cnt;
		logic tsr_full;
		logic [7:0] txbuf;
		logic txbuf_full;
		logic tx_nine_buf;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic data_out;
		logic data_oe;
		logic wake;
		logic vector;
		logic irq;
	} ssp_state_t;

	ssp_state_t s_reg, s_next;
	logic slave_mode, rx_mode, tx_mode, ck_rise, ck_fall, fifo_full;
	logic [3:0] word_bits;
	logic [8:0] rx_word;
	logic [2:0] evt_set;
	logic [7:0] wd;
	logic rx_hit, tx_hit, rx_irq, tx_irq;

	always_comb begin
		s_next = s_reg;
		s_next.ck_sync = {s_reg.ck_sync[0], SER_CLK_IN};
		s_next.dt_sync = {s_reg.dt_sync[0], SER_DATA_IN};
		s_next.ck_prev = s_reg.ck_sync[1];
		ck_rise = s_reg.ck_sync[1] & ~s_reg.ck_prev;
		ck_fall = ~s_reg.ck_sync[1] & s_reg.ck_prev;
		// runs from the sampled link clock only, so sleep does not stop it
		slave_mode = s_reg.txs[TX_SYNC] & s_reg.rxs[RX_SERIAL_PORT_ENABLE] & ~s_reg.txs[TX_CLOCK_SOURCE_MASTER];
		rx_mode = slave_mode & s_reg.rxs[RX_CONTINUOUS_RECEIVE_ENABLE];
		tx_mode = slave_mode & ~s_reg.rxs[RX_CONTINUOUS_RECEIVE_ENABLE] & ~s_reg.rxs[RX_SINGLE_RECEIVE_ENABLE] & s_reg.txs[TX_EN];
		word_bits = s_reg.rxs[RX_NINE] ? BITS_9 : BITS_8;
		fifo_full = (s_reg.fifo_cnt == 2'(FIFO_DEPTH));
		evt_set = '0;
		rx_word = '0;
		wd = HWDATA[7:0];
		// receive: sample data on rising edge of the master clock
		if (rx_mode && ck_rise) begin
			s_next.receive_shift_register = {s_reg.dt_sync[1], s_reg.receive_shift_register[8:1]};
			s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
			if (s_reg.rx_cnt + 4'h1 == word_bits) begin
				s_next.rx_cnt = '0;
				rx_word = s_reg.rxs[RX_NINE] ? {s_reg.dt_sync[1], s_reg.receive_shift_register[8:1]}
					: {1'b0, s_reg.dt_sync[1], s_reg.receive_shift_register[8:2]};
				if (fifo_full) begin
					s_next.rxs[RX_OVERRUN_ERROR] = 1'b1;
					evt_set[EV_OVR] = 1'b1;
				end else begin
					if (s_reg.fifo_cnt == 2'h0)
						s_next.fifo0 = rx_word;
					else
						s_next.fifo1 = rx_word;
					s_next.fifo_cnt = s_reg.fifo_cnt + 2'h1;
					evt_set[EV_RX] = 1'b1;
				end
			end
		end
		// transmit: shift out on falling edge, master samples on rising
		// a falling edge retires the bit that the master took on the rising edge before it
		if (tx_mode && s_reg.tsr_full && ck_fall) begin
			s_next.transmit_shift_register = {1'b0, s_reg.transmit_shift_register[8:1]};
			s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
			if (s_reg.tx_cnt + 4'h1 == (s_reg.txs[TX_NINE] ? BITS_9 : BITS_8)) begin
				s_next.tx_cnt = '0;
				s_next.tsr_full = s_reg.txbuf_full;
				if (s_reg.txbuf_full) begin
					s_next.transmit_shift_register = {s_reg.tx_nine_buf, s_reg.txbuf};
					s_next.txbuf_full = 1'b0;
					evt_set[EV_TX] = 1'b1;
				end
			end
		end
		s_next.data_oe = tx_mode;
		// bus read pop of the receive fifo
		if (s_reg.rd_pend && s_reg.addr == ADDR_RX_DATA && s_reg.fifo_cnt != 2'h0) begin
			s_next.fifo0 = s_next.fifo1;
			s_next.fifo_cnt = s_next.fifo_cnt - 2'h1;
		end
		s_next.rxs[RX_NINE_D] = (s_next.fifo_cnt != 2'h0) & s_next.fifo0[8];
		// bus write
		s_next.wr_pend = 1'b0;
		s_next.rd_pend = 1'b0;
		if (s_reg.wr_pend) begin
			case (s_reg.addr)
				ADDR_TX_STAT: s_next.txs = {wd[7:2], s_reg.txs[TX_TRMT], wd[0]};
				ADDR_RX_STAT: begin
					s_next.rxs[7:2] = wd[7:2];
					if (!wd[RX_CONTINUOUS_RECEIVE_ENABLE] || !wd[RX_SERIAL_PORT_ENABLE])
						s_next.rxs[RX_OVERRUN_ERROR] = evt_set[EV_OVR]; // same-cycle overrun wins while the port enable stays set
				end
				ADDR_TX_DATA: begin
					// next-state view so a word that ends this cycle frees its slot at once
					if (!s_next.tsr_full) begin
						s_next.transmit_shift_register = {s_reg.txs[TX_NINE_D], wd};
						s_next.tsr_full = 1'b1;
						s_next.tx_cnt = '0;
					end else if (!s_next.txbuf_full) begin
						s_next.txbuf = wd;
						s_next.tx_nine_buf = s_reg.txs[TX_NINE_D];
						s_next.txbuf_full = 1'b1;
					end
				end
				ADDR_CORE_IRQ: s_next.core_irq = wd;
				ADDR_PIE: s_next.pie = wd;
				ADDR_BAUD: s_next.baud[4:0] = wd[4:0];
				ADDR_ALT_PIN: s_next.alt_pin = wd;
				ADDR_EVT_STAT: s_next.evt = s_reg.evt & ~wd[2:0];
				ADDR_EVT_MASK: s_next.evt_mask = wd[2:0];
				default: ;
			endcase
		end
		// port enable cleared: whole port returns to idle
		if (!s_next.rxs[RX_SERIAL_PORT_ENABLE]) begin
			s_next.fifo_cnt = '0;
			s_next.rx_cnt = '0;
			s_next.tx_cnt = '0;
			s_next.tsr_full = 1'b0;
			s_next.txbuf_full = 1'b0;
			s_next.rxs[RX_OVERRUN_ERROR] = 1'b0;
		end
		if (!s_next.rxs[RX_CONTINUOUS_RECEIVE_ENABLE])
			s_next.rx_cnt = '0;
		// first bit stands before the first rising edge, as the master samples there
		s_next.data_out = tx_mode & s_next.tsr_full & s_next.transmit_shift_register[0];
		s_next.evt = s_next.evt | evt_set; // set wins over a same-cycle clear
		// flags are live views: receive pending, transmit buffer free
		s_next.pir[PI_RC] = (s_next.fifo_cnt != 2'h0);
		s_next.pir[PI_TX] = ~s_next.txbuf_full;
		s_next.txs[TX_TRMT] = ~s_next.tsr_full;
		s_next.baud[BAUD_RCIDL] = ~rx_mode; // continuous receive never idles
		rx_hit = s_reg.pir[PI_RC] & s_reg.pie[PI_RC];
		tx_hit = s_reg.pir[PI_TX] & s_reg.pie[PI_TX];
		rx_irq = rx_hit & s_reg.core_irq[CI_PERIPHERAL_IRQ_ENABLE];
		tx_irq = tx_hit & s_reg.core_irq[CI_PERIPHERAL_IRQ_ENABLE];
		s_next.wake = CORE_SLEEP & (rx_hit | tx_irq);
		s_next.vector = (rx_irq | tx_irq) & s_reg.core_irq[CI_GIE];
		s_next.irq = |(s_reg.evt & s_reg.evt_mask);
		// ahb-lite address phase capture; always zero wait
		if (HSEL && HREADY && HTRANS[1]) begin
			s_next.addr = HADDR[7:0];
			s_next.wr_pend = HWRITE;
			s_next.rd_pend = ~HWRITE;
		end
		s_next.rdata = '0;
		if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
			case (HADDR[7:0])
				ADDR_TX_STAT: s_next.rdata[7:0] = s_next.txs;
				ADDR_RX_STAT: s_next.rdata[7:0] = s_next.rxs;
				ADDR_RX_DATA: s_next.rdata[7:0] = s_next.fifo0[7:0];
				ADDR_CORE_IRQ: s_next.rdata[7:0] = s_next.core_irq;
				ADDR_PIE: s_next.rdata[7:0] = s_next.pie;
				ADDR_PIR: s_next.rdata[7:0] = s_next.pir;
				ADDR_BAUD: s_next.rdata[7:0] = s_next.baud;
				ADDR_ALT_PIN: s_next.rdata[7:0] = s_next.alt_pin;
				ADDR_EVT_STAT: s_next.rdata[2:0] = s_next.evt;
				ADDR_EVT_MASK: s_next.rdata[2:0] = s_next.evt_mask;
				ADDR_SLEEP: s_next.rdata[0] = CORE_SLEEP;
				default: s_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			s_reg <= '0;
			s_reg.txs <= TXS_RESET;
			s_reg.pir <= PIR_RESET;
			s_reg.baud <= BAUD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign HRDATA = s_reg.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign SER_DATA_OUT = s_reg.data_out;
	assign SER_DATA_OE = s_reg.data_oe;
	assign CORE_WAKE = s_reg.wake;
	assign CORE_VECTOR = s_reg.vector;
	assign IRQ = s_reg.irq;
endmodule : ssp_slave
`default_nettype wire

/* test/ssp_assertions.sv */
// checker for the slave serial port bus and link outputs
`timescale 1ns/1ns
`default_nettype none
module ssp_assertions(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic HREADY,
	input wire logic HWRITE,
	input wire logic [1:0] HTRANS,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic SER_CLK_IN,
	input wire logic SER_DATA_OUT,
	input wire logic SER_DATA_OE,
	input wire logic CORE_SLEEP,
	input wire logic CORE_WAKE,
	input wire logic IRQ
);
default clocking @(posedge CLK); endclocking
default disable iff (SYS_RST);
logic [2:0] since_wr;
// irq can only drop after a write to event status or event mask
always_ff @(posedge CLK) begin
	if (SYS_RST) since_wr <= 3'h7;
	else if (HSEL && HREADY && HTRANS[1] && HWRITE) since_wr <= 3'h0;
	else if (since_wr != 3'h7) since_wr <= since_wr + 3'h1;
end
property p_ready; HREADYOUT && !HRESP; endproperty
a_ready: assert property (p_ready) else $error("bus stall");
property p_rd_idle; !$past(HSEL && HREADY && HTRANS[1] && !HWRITE) |-> HRDATA == 32'h0; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
property p_rd_hi; HRDATA[31:8] == 24'h00_0000; endproperty
a_rd_hi: assert property (p_rd_hi) else $error("upper read bits");
property p_wake; CORE_WAKE |-> $past(CORE_SLEEP); endproperty
a_wake: assert property (p_wake) else $error("wake while awake");
property p_wake_drop; $fell(CORE_SLEEP) |=> !CORE_WAKE; endproperty
a_wake_drop: assert property (p_wake_drop) else $error("wake held");
property p_tx_hold; SER_DATA_OE && $rose(SER_CLK_IN) |=> $stable(SER_DATA_OUT) [*2]; endproperty
a_tx_hold: assert property (p_tx_hold) else $error("tx data moved");
property p_rst_quiet; $fell(SYS_RST) |-> !IRQ && !CORE_WAKE && !SER_DATA_OE; endproperty
a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
property p_irq_fall; $fell(IRQ) |-> since_wr < 3'h6; endproperty
a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule : ssp_assertions
bind ssp_slave ssp_assertions ssp_assertions_inst(.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL),
	.HREADY(HREADY), .HWRITE(HWRITE), .HTRANS(HTRANS), .HRDATA(HRDATA), .HRESP(HRESP),
	.HREADYOUT(HREADYOUT), .SER_CLK_IN(SER_CLK_IN), .SER_DATA_OUT(SER_DATA_OUT),
	.SER_DATA_OE(SER_DATA_OE), .CORE_SLEEP(CORE_SLEEP), .CORE_WAKE(CORE_WAKE), .IRQ(IRQ));
`default_nettype wire

/* test/ssp_master.sv */
// far-end master: makes the link clock, drives and samples the data line
`timescale 1ns/1ns
`default_nettype none
module ssp_master(
	output logic ser_clk,
	output logic ser_data,
	input wire logic dev_data
);
initial begin
	ser_clk = 1'h0;
	ser_data = 1'h0;
end
// one pulse per bit, lsb first, clock rests low between words
task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
	rx = 9'h000;
	#5;
	for (int i = 0; i < n; i++) begin
		ser_data = tx[i];
		#160 ser_clk = 1'h1;
		rx[i] = dev_data;
		#160 ser_clk = 1'h0;
	end
	// released line must not keep a stale level
	ser_data = ~ser_data;
endtask : xfer
endmodule : ssp_master
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the synchronous slave serial port
`timescale 1ns/1ns
`default_nettype none
module tb;
import ssp_pkg::*;
logic CLK = 1'h0;
logic SYS_RST = 1'h1;
logic HWRITE = 1'h0;
logic CORE_SLEEP = 1'h0;
logic [1:0] HTRANS = 2'h0;
logic [31:0] HADDR = 32'h0;
logic [31:0] HWDATA = 32'h0;
logic [31:0] HRDATA;
logic HREADYOUT, HRESP, SER_DATA_OUT, SER_DATA_OE, CORE_WAKE, CORE_VECTOR, IRQ, m_data, m_clk;
wire logic pin;
int bad_count = 0;
int comparisons = 0;
assign pin = SER_DATA_OE ? SER_DATA_OUT : m_data;
always #20 CLK = ~CLK;
ssp_slave ssp_slave_inst(.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(1'h1), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
	.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SER_CLK_IN(m_clk),
	.SER_DATA_IN(pin), .SER_DATA_OUT(SER_DATA_OUT), .SER_DATA_OE(SER_DATA_OE),
	.CORE_SLEEP(CORE_SLEEP), .CORE_WAKE(CORE_WAKE), .CORE_VECTOR(CORE_VECTOR), .IRQ(IRQ));
ssp_master ssp_master_inst(.ser_clk(m_clk), .ser_data(m_data), .dev_data(pin));
task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
	comparisons++;
	if (s !== e) begin
		bad_count++;
		$display("[ERR] %s expected %h seen %h", n, e, s);
	end
endtask : chk
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
	HTRANS <= 2'h2;
	HWRITE <= w;
	HADDR <= {24'h00_0000, a};
	do @(posedge CLK); while (HREADYOUT !== 1'h1);
	HTRANS <= 2'h0;
	HWDATA <= d;
	do @(posedge CLK); while (HREADYOUT !== 1'h1);
	r = HRDATA;
endtask : bus
task automatic wr(input logic [7:0] a, input logic [31:0] d);
	logic [31:0] r;
	bus(1'h1, a, d, r);
endtask : wr
task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
	logic [31:0] r;
	bus(1'h0, a, 32'h0, r);
	chk(e, r, n);
endtask : rd
task automatic word(input logic [8:0] tx, input int n, output logic [8:0] rx);
	ssp_master_inst.xfer(tx, n, rx);
	repeat (6) @(posedge CLK);
endtask : word
task automatic t_regs;
	rd(ADDR_TX_STAT, 32'(TXS_RESET), "txstat");
	rd(ADDR_PIR, 32'(PIR_RESET), "pir");
	wr(8'h30, 32'h00ff);
	rd(8'h30, 32'h0, "unmapped");
endtask : t_regs
task automatic t_rx;
	logic [8:0] r;
	wr(ADDR_TX_STAT, 32'h0010);
	wr(ADDR_RX_STAT, 32'h00b0);
	wr(ADDR_PIE, 32'h0020);
	wr(ADDR_CORE_IRQ, 32'h00c0);
	wr(ADDR_EVT_MASK, 32'h0001);
	rd(ADDR_BAUD, 32'h0, "idle");
	chk(32'h0, 32'(SER_DATA_OE), "rxoe");
	word(9'h0a5, 8, r);
	rd(ADDR_PIR, 32'h0030, "rxflag");
	chk(32'h0003, {30'h0, CORE_VECTOR, IRQ}, "pins");
	rd(ADDR_RX_DATA, 32'h00a5, "rxdata");
	rd(ADDR_PIR, 32'h0010, "drained");
	wr(ADDR_EVT_MASK, 32'h0);
	rd(ADDR_EVT_STAT, 32'h0001, "evt");
	chk(32'h0, 32'(IRQ), "masked");
	wr(ADDR_EVT_STAT, 32'h0001);
	wr(ADDR_EVT_MASK, 32'h0001);
	rd(ADDR_EVT_STAT, 32'h0, "evtclr");
	chk(32'h0, 32'(IRQ), "cleared");
endtask : t_rx
task automatic t_ovr;
	logic [8:0] r;
	wr(ADDR_RX_STAT, 32'h00d0);
	word(9'h13c, 9, r);
	word(9'h055, 9, r);
	word(9'h1ff, 9, r);
	rd(ADDR_RX_STAT, 32'h00d3, "ovr9");
	rd(ADDR_RX_DATA, 32'h003c, "oldest");
	rd(ADDR_RX_STAT, 32'h00d2, "ninth2");
	rd(ADDR_RX_DATA, 32'h0055, "second");
	wr(ADDR_RX_STAT, 32'h00c0);
	rd(ADDR_RX_STAT, 32'h00c0, "ovrclr");
	wr(ADDR_RX_STAT, 32'h0090);
	wr(ADDR_CORE_IRQ, 32'h0040);
	CORE_SLEEP <= 1'h1;
	word(9'h081, 8, r);
	chk(32'h0002, {30'h0, CORE_WAKE, CORE_VECTOR}, "rxwake");
	CORE_SLEEP <= 1'h0;
	rd(ADDR_RX_DATA, 32'h0081, "sleepword");
endtask : t_ovr
task automatic t_tx;
	logic [8:0] r;
	// transmit needs both receive enables clear
	wr(ADDR_RX_STAT, 32'h0080);
	wr(ADDR_TX_STAT, 32'h0030);
	wr(ADDR_PIE, 32'h0010);
	chk(32'h1, 32'(SER_DATA_OE), "txoe");
	wr(ADDR_TX_DATA, 32'h003c);
	rd(ADDR_PIR, 32'h0010, "tsronly");
	rd(ADDR_TX_STAT, 32'h0030, "trmt");
	wr(ADDR_TX_DATA, 32'h00c3);
	rd(ADDR_PIR, 32'h0, "txfull");
	CORE_SLEEP <= 1'h1;
	word(9'h000, 8, r);
	chk(32'h003c, 32'(r), "out1");
	chk(32'h0001, 32'(CORE_WAKE), "txwake");
	rd(ADDR_PIR, 32'h0010, "reload");
	wr(ADDR_TX_DATA, 32'h005a);
	rd(ADDR_PIR, 32'h0, "refill");
	word(9'h000, 8, r);
	chk(32'h00c3, 32'(r), "out2");
	CORE_SLEEP <= 1'h0;
endtask : t_tx
task automatic end_of_test;
	$display("comparisons %0d mismatches %0d", comparisons, bad_count);
	if (bad_count == 0 && comparisons > 0) begin
		$display("Simulation passed");
	end else begin
		$display("Simulation failed");
	end
	$finish;
endtask : end_of_test
initial begin
	repeat (4) @(posedge CLK);
	SYS_RST <= 1'h0;
	t_regs();
	t_rx();
	t_ovr();
	t_tx();
	end_of_test();
end
initial begin
	#2000000;
	bad_count++;
	end_of_test();
end
endmodule : tb
`default_nettype wire
